// >>> hdl/fsp_pkg.sv
package fsp_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFS_CUSTOMER_COMPENSATED_FIELD = 8'h00;
  localparam logic [7:0] OFS_LIN_IN = 8'h04;
  localparam logic [7:0] OFS_LIN_OUT = 8'h08;
  localparam logic [7:0] OFS_OUT_SCALED = 8'h0c;
  localparam logic [7:0] OFS_FINAL = 8'h10;
  localparam logic [7:0] OFS_PROD_A = 8'h14;
  localparam logic [7:0] OFS_PROD_B = 8'h18;
  localparam logic [7:0] OFS_SELF_TEST = 8'h1c;
  localparam logic [7:0] OFS_PROG_ERR = 8'h20;
  localparam logic [7:0] OFS_USER_A = 8'h24;
  localparam logic [7:0] OFS_USER_B = 8'h28;
  localparam logic [7:0] OFS_GCOEF0 = 8'h2c;
  localparam logic [7:0] OFS_GCOEF1 = 8'h30;
  localparam logic [7:0] OFS_GCOEF2 = 8'h34;
  localparam logic [7:0] OFS_OCOEF0 = 8'h38;
  localparam logic [7:0] OFS_OCOEF1 = 8'h3c;
  localparam logic [7:0] OFS_SETUP = 8'h40;
  localparam logic [7:0] OFS_SCALE_GAIN = 8'h44;
  localparam logic [7:0] OFS_SCALE_OFS = 8'h48;
  localparam logic [7:0] OFS_OUT_GAIN = 8'h4c;
  localparam logic [7:0] OFS_OUT_OFS = 8'h50;
  localparam logic [7:0] OFS_RAW_FIELD = 8'h54;
  localparam logic [7:0] OFS_TEMP = 8'h58;
  localparam logic [7:0] OFS_LINEARIZED_VALUE_BASE = 8'h80;
  // Field positions.
  localparam int SETUP_RANGE_LSB = 12;
  localparam int SETUP_PWM_LSB = 10;
  localparam int ST_FSM_BIT = 5;
  localparam int ST_NVM_BIT = 4;
  localparam int ST_ROM_BIT = 3;
  localparam int ST_ADC_BIT = 2;
  localparam int PE_VPGM_BIT = 10;
  localparam int PE_VSUP_BIT = 9;
  localparam int PE_NVRAM_BIT = 8;
  localparam int LIN_SEG_BITS = 11;
  // Reset values; unity gain in Q15 is the largest positive code.
  localparam logic [15:0] RST_UNITY = 16'h7fff;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_SETUP = 16'h1000;
  localparam logic signed [15:0] SAT_POS = 16'sh7fff;
  localparam logic signed [15:0] SAT_NEG = -16'sh7fff - 16'sh0001;

  typedef enum logic [1:0] {
    FSP_PWM_1K, FSP_PWM_500, FSP_PWM_250, FSP_PWM_2K
  } fsp_pwm_t;

  typedef enum logic {FSP_POWERUP, FSP_RUN} fsp_state_t;

  typedef struct packed {
    logic fsm_fail;
    logic nvm_fail;
    logic rom_fail;
    logic adc_ovf;
    logic vpgm_low;
    logic vsup_low;
    logic nvram_fail;
  } fsp_events_t;
endpackage

// >>> hdl/fsp_regs.sv
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
// Function
// - Readout of field after customer temperature gain and offset correction.
// - Gain is quadratic polynomial of temperature, three signed 16-bit coefs.
// - Offset is linear polynomial of temperature, two signed 16-bit coefs.
// - Readout of field after input scaling into linearizer range.
// - Readout of field after sixteen-setpoint linearization.
// - Readout of field after output gain and offset scaling.
// - Final path value is readable and drives the output conversion.
// - Two read-only production information words.
// - Setup bits 11:10 pick pulse rate; code 11 gives 11-bit resolution.
// - Status bit 5 set on control state machine self-test failure.
// - Memory self test only at power-up; failure sets status bit 4.
// - Continuous ROM parity check failure sets status bit 3.
// - Converter overrange sets status bit 2; other bits reserved zero.
// - Program error bits 10, 9, 8: low voltage, low supply, failure.
// - Range field at setup bits 14:12 picks 16 of 22 filter bits.
// - Code 1 takes bits 21..6, one bit lower per step to code 6.
// - Overrange raw field saturates to the 16-bit limit of its sign.
// - Setpoints are differential; all zero passes non-negative input unchanged, negative clamps to zero.
// - Two freely writable and readable user identification words.
// - Polynomials use the calibrated signed 16-bit temperature reading.
module fsp_regs #(
  parameter logic [15:0] PROD_INFO_A = 16'h0000, // Arbitrary value.
  parameter logic [15:0] PROD_INFO_B = 16'h0000  // Arbitrary value.
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_sample_valid,
  input wire logic [21:0] i_filter_word,
  input wire logic [15:0] i_factory_field,
  input wire logic [15:0] i_calibrated_temp,
  input wire fsp_pkg::fsp_events_t i_events,
  output logic [15:0] o_final_value,
  output fsp_pkg::fsp_pwm_t o_pulse_rate_select,
  output logic o_pulse_res_11bit
);
  import fsp_pkg::*;

  logic [15:0] customer_compensated_field_r, lin_in_r, lin_out_r, out_scaled_r, final_r;
  logic [15:0] raw_field_r, temp_r;
  logic [15:0] self_test_r, prog_err_r;
  logic [15:0] user_a_r, user_b_r, setup_r;
  logic [15:0] gcoef_r [3];
  logic [15:0] ocoef_r [2];
  logic [15:0] scale_gain_r, scale_ofs_r, out_gain_r, out_ofs_r;
  logic [15:0] linearized_value_r [16];
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic pulse_res_r;
  fsp_state_t state_r;

  function automatic logic [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'(SAT_POS)) begin
      return SAT_POS;
    end else if (v < 34'(SAT_NEG)) begin
      return SAT_NEG;
    end
    return v[15:0];
  endfunction

  function automatic logic signed [33:0] ext(input logic [15:0] a);
    return 34'($signed(a));
  endfunction

  // Q15 multiply with saturation; -1 times -1 would otherwise wrap.
  function automatic logic [15:0] mul_q15(input logic [15:0] a,
                                          input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    p = p >>> 15;
    return sat16(34'(p));
  endfunction

  // Codes 0 and 7 fall back to the widest range, since bit 22 is absent.
  function automatic logic [16:0] barrel(input logic [21:0] w,
                                         input logic [2:0] code);
    logic signed [21:0] s;
    logic [2:0] c;
    logic ovf;
    c = (code == 3'd0 || code == 3'd7) ? 3'd1 : code;
    s = $signed(w) >>> (3'd7 - c);
    ovf = (s[21:15] != {7{s[15]}});
    if (ovf) begin
      return {1'b1, (w[21] ? SAT_NEG : SAT_POS)};
    end
    return {1'b0, s[15:0]};
  endfunction

  // Decode of the APB address, shared by the read and write paths.
  function automatic logic is_linearized_value(input logic [7:0] a);
    return a[7:6] == OFS_LINEARIZED_VALUE_BASE[7:6] && a[1:0] == 2'b00;
  endfunction

  // Only the fastest pulse rate drops to the shorter resolution.
  function automatic logic is_fast_rate(input logic [1:0] code);
    return code == 2'b11;
  endfunction

  logic [15:0] gain_w, cust_w, lin_in_w, lin_w, out_w, t2_w;
  logic [16:0] raw_w;

  always_comb begin
    t2_w = mul_q15(i_calibrated_temp, i_calibrated_temp);
    gain_w = sat16(ext(gcoef_r[0]) + ext(mul_q15(gcoef_r[1],
                   i_calibrated_temp)) + ext(mul_q15(gcoef_r[2], t2_w)));
    cust_w = sat16(ext(mul_q15(i_factory_field, gain_w)) + ext(ocoef_r[0])
                   + ext(mul_q15(ocoef_r[1], i_calibrated_temp)));
    lin_in_w = sat16(ext(mul_q15(cust_w, scale_gain_r)) + ext(scale_ofs_r));
  end

  // Linearizer: 16 segments of 2048 codes over 0..32767; each setpoint is
  // the extra rise of its segment, so the curve is x plus the running sum.
  always_comb begin
    logic [15:0] x;
    logic [3:0] seg;
    logic signed [33:0] acc;
    logic signed [33:0] part;
    x = lin_in_w[15] ? 16'h0000 : lin_in_w;
    seg = x[14:11];
    acc = ext(x);
    part = '0;
    for (int i = 0; i < 16; i++) begin
      if (4'(i) < seg) begin
        acc = acc + ext(linearized_value_r[i]);
      end
    end
    part = ext(linearized_value_r[seg]) * $signed({23'h0, x[10:0]});
    acc = acc + (part >>> LIN_SEG_BITS);
    lin_w = sat16(acc);
    out_w = sat16(ext(mul_q15(lin_w, out_gain_r)) + ext(out_ofs_r));
  end

  assign raw_w = barrel(i_filter_word, setup_r[SETUP_RANGE_LSB +: 3]);

  // Path taps update together on each new sample.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      raw_field_r <= RST_ZERO;
      temp_r <= RST_ZERO;
      customer_compensated_field_r <= RST_ZERO;
      lin_in_r <= RST_ZERO;
      lin_out_r <= RST_ZERO;
      out_scaled_r <= RST_ZERO;
      final_r <= RST_ZERO;
    end else if (i_sample_valid) begin
      raw_field_r <= raw_w[15:0];
      temp_r <= i_calibrated_temp;
      customer_compensated_field_r <= cust_w;
      lin_in_r <= lin_in_w;
      lin_out_r <= lin_w;
      out_scaled_r <= out_w;
      final_r <= out_w;
    end
  end

  // Power-up window lasts one cycle after reset release.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_r <= FSP_POWERUP;
    end else begin
      case (state_r)
        FSP_POWERUP: state_r <= FSP_RUN;
        FSP_RUN: state_r <= FSP_RUN;
        default: state_r <= FSP_POWERUP;
      endcase
    end
  end

  // Status bits are sticky until reset; software cannot clear them.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      self_test_r <= RST_ZERO;
      prog_err_r <= RST_ZERO;
    end else begin
      if (i_events.fsm_fail) begin
        self_test_r[ST_FSM_BIT] <= 1'b1;
      end
      if (i_events.nvm_fail && state_r == FSP_POWERUP) begin
        self_test_r[ST_NVM_BIT] <= 1'b1;
      end
      if (i_events.rom_fail) begin
        self_test_r[ST_ROM_BIT] <= 1'b1;
      end
      if (i_events.adc_ovf || (i_sample_valid && raw_w[16])) begin
        self_test_r[ST_ADC_BIT] <= 1'b1;
      end
      if (i_events.vpgm_low) begin
        prog_err_r[PE_VPGM_BIT] <= 1'b1;
      end
      if (i_events.vsup_low) begin
        prog_err_r[PE_VSUP_BIT] <= 1'b1;
      end
      if (i_events.nvram_fail) begin
        prog_err_r[PE_NVRAM_BIT] <= 1'b1;
      end
    end
  end

  logic wr_en;
  assign wr_en = i_psel && i_penable && i_pwrite && pready_r;

  // Writable registers; readout and status offsets have no write path.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      user_a_r <= RST_ZERO;
      user_b_r <= RST_ZERO;
      setup_r <= RST_SETUP;
      pulse_res_r <= is_fast_rate(RST_SETUP[SETUP_PWM_LSB +: 2]);
      gcoef_r[0] <= RST_UNITY;
      gcoef_r[1] <= RST_ZERO;
      gcoef_r[2] <= RST_ZERO;
      ocoef_r[0] <= RST_ZERO;
      ocoef_r[1] <= RST_ZERO;
      scale_gain_r <= RST_UNITY;
      scale_ofs_r <= RST_ZERO;
      out_gain_r <= RST_UNITY;
      out_ofs_r <= RST_ZERO;
      for (int i = 0; i < 16; i++) begin
        linearized_value_r[i] <= RST_ZERO;
      end
    end else if (wr_en) begin
      case (i_paddr)
        OFS_USER_A: user_a_r <= i_pwdata[15:0];
        OFS_USER_B: user_b_r <= i_pwdata[15:0];
        OFS_SETUP: begin
          setup_r <= i_pwdata[15:0];
          // Kept as its own flop so the resolution flag leaves a register.
          pulse_res_r <= is_fast_rate(i_pwdata[SETUP_PWM_LSB +: 2]);
        end
        OFS_GCOEF0: gcoef_r[0] <= i_pwdata[15:0];
        OFS_GCOEF1: gcoef_r[1] <= i_pwdata[15:0];
        OFS_GCOEF2: gcoef_r[2] <= i_pwdata[15:0];
        OFS_OCOEF0: ocoef_r[0] <= i_pwdata[15:0];
        OFS_OCOEF1: ocoef_r[1] <= i_pwdata[15:0];
        OFS_SCALE_GAIN: scale_gain_r <= i_pwdata[15:0];
        OFS_SCALE_OFS: scale_ofs_r <= i_pwdata[15:0];
        OFS_OUT_GAIN: out_gain_r <= i_pwdata[15:0];
        OFS_OUT_OFS: out_ofs_r <= i_pwdata[15:0];
        default: begin
          if (is_linearized_value(i_paddr)) begin
            linearized_value_r[i_paddr[5:2]] <= i_pwdata[15:0];
          end
        end
      endcase
    end
  end

  logic [15:0] rd_w;
  logic rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    rd_w = RST_ZERO;
    case (i_paddr)
      OFS_CUSTOMER_COMPENSATED_FIELD: rd_w = customer_compensated_field_r;
      OFS_LIN_IN: rd_w = lin_in_r;
      OFS_LIN_OUT: rd_w = lin_out_r;
      OFS_OUT_SCALED: rd_w = out_scaled_r;
      OFS_FINAL: rd_w = final_r;
      OFS_PROD_A: rd_w = PROD_INFO_A;
      OFS_PROD_B: rd_w = PROD_INFO_B;
      OFS_SELF_TEST: rd_w = self_test_r;
      OFS_PROG_ERR: rd_w = prog_err_r;
      OFS_USER_A: rd_w = user_a_r;
      OFS_USER_B: rd_w = user_b_r;
      OFS_GCOEF0: rd_w = gcoef_r[0];
      OFS_GCOEF1: rd_w = gcoef_r[1];
      OFS_GCOEF2: rd_w = gcoef_r[2];
      OFS_OCOEF0: rd_w = ocoef_r[0];
      OFS_OCOEF1: rd_w = ocoef_r[1];
      OFS_SETUP: rd_w = setup_r;
      OFS_SCALE_GAIN: rd_w = scale_gain_r;
      OFS_SCALE_OFS: rd_w = scale_ofs_r;
      OFS_OUT_GAIN: rd_w = out_gain_r;
      OFS_OUT_OFS: rd_w = out_ofs_r;
      OFS_RAW_FIELD: rd_w = raw_field_r;
      OFS_TEMP: rd_w = temp_r;
      default: begin
        rd_hit = is_linearized_value(i_paddr);
        rd_w = linearized_value_r[i_paddr[5:2]];
        if (!rd_hit) begin
          rd_w = RST_ZERO;
        end
      end
    endcase
  end

  // Read data is captured in the setup cycle so the access phase
  // completes with zero wait states and registered outputs.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= i_psel && !i_penable;
      pslverr_r <= i_psel && !i_penable && !rd_hit;
      if (i_psel && !i_penable && !i_pwrite) begin
        prdata_r <= {16'h0000, rd_w};
      end
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_final_value = final_r;
  assign o_pulse_rate_select = fsp_pwm_t'(setup_r[SETUP_PWM_LSB +: 2]);
  assign o_pulse_res_11bit = pulse_res_r;

  logic past_valid_r;
  always_ff @(posedge i_clock) begin
    past_valid_r <= !i_srst;
  end

  setup_ready_a: assert property (@(posedge i_clock) disable iff (i_srst)
    i_psel && !i_penable |=> o_pready)
    else $error("Setup cycle not answered in one cycle.");
  final_tap_a: assert property (@(posedge i_clock) disable iff (i_srst)
    past_valid_r && i_sample_valid
    |=> o_final_value == out_scaled_r && final_r == $past(out_w))
    else $error("Final value does not follow the scaled value.");
  fsm_sticky_a: assert property (@(posedge i_clock) disable iff (i_srst)
    i_events.fsm_fail |=> self_test_r[ST_FSM_BIT] [*3])
    else $error("State machine fail bit not sticky.");
  nvm_window_a: assert property (@(posedge i_clock) disable iff (i_srst)
    state_r == FSP_RUN && !self_test_r[ST_NVM_BIT] |=> !self_test_r[ST_NVM_BIT])
    else $error("Memory self-test bit set after power-up.");
  rom_flag_a: assert property (@(posedge i_clock) disable iff (i_srst)
    i_events.rom_fail |=> self_test_r[ST_ROM_BIT])
    else $error("ROM parity fail not flagged.");
  reserved_a: assert property (@(posedge i_clock) disable iff (i_srst)
    self_test_r[15:6] == 10'h000 && self_test_r[1:0] == 2'b00
    && prog_err_r[15:11] == 5'h00)
    else $error("Reserved status bits set.");
  pgm_flag_a: assert property (@(posedge i_clock) disable iff (i_srst)
    i_events.vpgm_low ##1 i_events.vsup_low |=> prog_err_r[10:9] == 2'b11)
    else $error("Program error bits not set.");
  ro_write_a: assert property (@(posedge i_clock) disable iff (i_srst)
    wr_en && i_paddr == OFS_SELF_TEST && !(|i_events)
    && !(i_sample_valid && raw_w[16])
    |=> $stable(self_test_r))
    else $error("Write changed a status register.");
  pwm_res_a: assert property (@(posedge i_clock) disable iff (i_srst)
    wr_en && i_paddr == OFS_SETUP && i_pwdata[11:10] == 2'b11
    |=> o_pulse_res_11bit && o_pulse_rate_select == FSP_PWM_2K)
    else $error("Pulse rate setting not applied.");
  unmapped_a: assert property (@(posedge i_clock) disable iff (i_srst)
    i_psel && !i_penable && !i_pwrite && !rd_hit
    |=> o_pslverr && o_prdata == 0)
    else $error("Unmapped address not refused.");
  nvm_flag_a: assert property (@(posedge i_clock) disable iff (i_srst)
    state_r == FSP_POWERUP && i_events.nvm_fail |=> self_test_r[ST_NVM_BIT])
    else $error("Memory self-test failure not flagged.");
  user_write_a: assert property (@(posedge i_clock) disable iff (i_srst)
    wr_en && i_paddr == OFS_USER_A |=> user_a_r == $past(i_pwdata[15:0]))
    else $error("User word write not stored.");
  saturate_a: assert property (@(posedge i_clock) disable iff (i_srst)
    i_sample_valid && raw_w[16]
    |=> raw_field_r == ($past(i_filter_word[21]) ? SAT_NEG : SAT_POS))
    else $error("Overrange raw field not saturated.");

  write_cov: cover property (@(posedge i_clock) disable iff (i_srst)
    wr_en && i_paddr == OFS_USER_A);
  sat_cov: cover property (@(posedge i_clock) disable iff (i_srst)
    i_sample_valid && raw_w[16]);
  linearized_value_cov: cover property (@(posedge i_clock) disable iff (i_srst)
    wr_en && is_linearized_value(i_paddr) ##[1:20] i_sample_valid);
  nvm_cov: cover property (@(posedge i_clock) disable iff (i_srst)
    state_r == FSP_POWERUP && i_events.nvm_fail);
endmodule

// >>> tb/fsp_programmer.sv
`timescale 1ns/1ns
module fsp_programmer (
  input wire logic i_clock,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic o_hang
);
  import fsp_pkg::*;
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0000_0000;
    o_hang = 1'b0;
  end
  // Normalised coefficients from -1 up to just below +1 are stored as Q15 codes.
  function automatic logic [15:0] norm_coef(input real n);
    return 16'($rtoi(n * 32768.0));
  endfunction
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    n = 0;
    @(posedge i_clock);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clock);
    o_penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (i_pready !== 1'b1 && n < 16);
    if (i_pready !== 1'b1) o_hang <= 1'b1;
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Released lines show the inverse, so stale values never look valid.
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
  // Every write is followed by a look at the program error status.
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    output logic [31:0] pe);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, {16'h0000, d}, q, e);
    xfer(1'b0, OFS_PROG_ERR, 32'h0000_0000, pe, e);
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import fsp_pkg::*;
  logic i_clock;
  logic i_srst;
  logic i_sample_valid;
  logic [21:0] i_filter_word;
  logic [15:0] i_factory_field;
  logic [15:0] i_calibrated_temp;
  fsp_events_t i_events;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic hang;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [15:0] final_value;
  fsp_pwm_t rate;
  logic res11;
  int errors;
  int comparisons;
  fsp_regs #(
    .PROD_INFO_A(16'h5a5a), // Arbitrary value.
    .PROD_INFO_B(16'h0c3c)  // Arbitrary value.
  ) i_fsp_regs (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_sample_valid(i_sample_valid),
    .i_filter_word(i_filter_word),
    .i_factory_field(i_factory_field),
    .i_calibrated_temp(i_calibrated_temp),
    .i_events(i_events),
    .o_final_value(final_value),
    .o_pulse_rate_select(rate),
    .o_pulse_res_11bit(res11)
  );
  fsp_programmer i_fsp_programmer (
    .i_clock(i_clock),
    .i_prdata(prdata),
    .i_pready(pready),
    .i_pslverr(pslverr),
    .o_psel(psel),
    .o_penable(penable),
    .o_pwrite(pwrite),
    .o_paddr(paddr),
    .o_pwdata(pwdata),
    .o_hang(hang)
  );
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  task automatic give_verdict;
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge hang) begin
    errors++;
    give_verdict();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    i_fsp_programmer.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
    chk({31'h0, e}, 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] pe;
    i_fsp_programmer.wr(a, d, pe);
    chk(pe, 32'h0000_0000);
  endtask
  task automatic do_reset(input logic nvm);
    @(posedge i_clock);
    i_srst <= 1'b1;
    repeat (20) @(posedge i_clock);
    i_srst <= 1'b0;
    i_events.nvm_fail <= nvm;
    repeat (2) @(posedge i_clock);
    i_events <= '0;
  endtask
  task automatic sample(input logic [21:0] w, input logic [15:0] f,
                        input logic [15:0] t);
    @(posedge i_clock);
    i_filter_word <= w;
    i_factory_field <= f;
    i_calibrated_temp <= t;
    i_sample_valid <= 1'b1;
    @(posedge i_clock);
    i_sample_valid <= 1'b0;
  endtask
  task automatic pulse(input logic [6:0] ev);
    @(posedge i_clock);
    i_events <= fsp_events_t'(ev);
    @(posedge i_clock);
    i_events <= '0;
  endtask
  function automatic int q15(input int a, input int b);
    return (a * b) >>> 15;
  endfunction
  function automatic logic [31:0] raw_exp(input logic [21:0] w,
                                          input int code);
    int v;
    v = int'(signed'(w)) >>> (7 - code);
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return {16'h0000, 16'(v)};
  endfunction
  task automatic t_basic;
    logic [31:0] q;
    logic e;
    chk({16'h0000, final_value}, 32'h0000_0000);
    rd(OFS_SETUP, 32'h0000_1000);
    rd(OFS_GCOEF0, 32'h0000_7fff);
    rd(OFS_PROD_A, 32'h0000_5a5a);
    wr(OFS_PROD_B, 16'h1111);
    rd(OFS_PROD_B, 32'h0000_0c3c);
    wr(OFS_FINAL, 16'h1234);
    rd(OFS_FINAL, 32'h0000_0000);
    wr(OFS_SELF_TEST, 16'hffff);
    rd(OFS_SELF_TEST, 32'h0000_0000);
    i_fsp_programmer.xfer(1'b0, 8'h5c, 32'h0000_0000, q, e);
    chk({q[31:1], e}, 32'h0000_0001);
  endtask
  task automatic t_user;
    wr(OFS_USER_A, 16'ha5c3);
    wr(OFS_USER_B, 16'h8001);
    rd(OFS_USER_A, 32'h0000_a5c3);
    rd(OFS_USER_B, 32'h0000_8001);
  endtask
  task automatic t_pwm;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_SETUP, {4'h1, 2'(c), 10'h000});
      chk({30'h0, rate}, 32'(c));
      chk({31'h0, res11}, {31'h0, c == 3});
    end
  endtask
  task automatic t_path;
    int g;
    int c;
    int l;
    wr(OFS_GCOEF0, i_fsp_programmer.norm_coef(0.5));
    wr(OFS_GCOEF1, i_fsp_programmer.norm_coef(0.25));
    wr(OFS_GCOEF2, i_fsp_programmer.norm_coef(0.25));
    wr(OFS_OCOEF0, 16'h0100);
    wr(OFS_OCOEF1, i_fsp_programmer.norm_coef(0.125));
    rd(OFS_GCOEF1, 32'h0000_2000);
    sample(22'h00_0000, 16'h2000, 16'h4000);
    g = 16384 + q15(8192, 16384) + q15(8192, q15(16384, 16384));
    c = q15(8192, g) + 256 + q15(4096, 16384);
    rd(OFS_CUSTOMER_COMPENSATED_FIELD, 32'(c));
    l = q15(c, 32767);
    rd(OFS_LIN_IN, 32'(l));
    rd(OFS_LIN_OUT, 32'(l));
    rd(OFS_OUT_SCALED, 32'(q15(l, 32767)));
    rd(OFS_FINAL, 32'(q15(l, 32767)));
    chk({16'h0000, final_value}, 32'(q15(l, 32767)));
    wr(OFS_LINEARIZED_VALUE_BASE + 8'h04, 16'h0064);
    sample(22'h00_0000, 16'h2000, 16'h4000);
    rd(OFS_LIN_OUT, 32'(l + 100));
  endtask
  task automatic t_range;
    wr(OFS_SETUP, 16'h7000);
    sample(22'h3f_5a5b, 16'h0000, 16'h0000);
    rd(OFS_RAW_FIELD, raw_exp(22'h3f_5a5b, 1));
    for (int k = 1; k < 7; k++) begin
      wr(OFS_SETUP, {1'b0, 3'(k), 12'h000});
      sample(22'h3f_5a5b, 16'h0000, 16'h0000);
      rd(OFS_RAW_FIELD, raw_exp(22'h3f_5a5b, k));
    end
    rd(OFS_SELF_TEST, 32'h0000_0000);
    sample(22'h1f_0000, 16'h0000, 16'h0000);
    rd(OFS_RAW_FIELD, 32'h0000_7fff);
    sample(22'h20_0000, 16'h0000, 16'h0000);
    rd(OFS_RAW_FIELD, 32'h0000_8000);
    rd(OFS_SELF_TEST, 32'(1 << ST_ADC_BIT));
  endtask
  task automatic t_events;
    logic [31:0] st;
    logic [31:0] pe;
    do_reset(1'b0);
    st = 32'h0000_0000;
    pe = 32'h0000_0000;
    pulse(7'h20);
    rd(OFS_SELF_TEST, st);
    // Event k of the struct maps to status bit k-1 or error bit k+8.
    for (int k = 0; k < 7; k++) begin
      if (k != 5) begin
        pulse(7'(1 << k));
        if (k >= 3) st[k - 1] = 1'b1;
        else pe[k + 8] = 1'b1;
        rd(OFS_SELF_TEST, st);
        rd(OFS_PROG_ERR, pe);
      end
    end
    do_reset(1'b1);
    rd(OFS_SELF_TEST, 32'(1 << ST_NVM_BIT));
    rd(OFS_PROG_ERR, 32'h0000_0000);
  endtask
  initial begin
    errors = 0;
    comparisons = 0;
    i_srst = 1'b1;
    i_sample_valid = 1'b0;
    i_filter_word = '0;
    i_factory_field = '0;
    i_calibrated_temp = '0;
    i_events = '0;
    do_reset(1'b0);
    t_basic();
    t_user();
    t_pwm();
    t_path();
    t_range();
    t_events();
    give_verdict();
  end
endmodule
